// [hdl/smc_defines.svh]
// constants for the slipping motion counters
// assumes inclusion by bare name from hdl/
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_NIB_MAX 4'hf
`define SMC_NIB_ZERO 4'h0
`define SMC_H_PRESET_STOP 4'h4
`define SMC_V_PRESET_STOP 4'h8
`define SMC_H_RELOAD_HI 8'h00
`define SMC_V_RELOAD_HI 4'h0
`define SMC_H_RELOAD_NIB1 4'h0
`define SMC_H_RELOAD_NIB2 4'h0
`define SMC_WIN_H_NIB1 4'hf
`define SMC_WIN_H_NIB2 4'hf
`define SMC_WIN_H_TOP 8'hff
`define SMC_WIN_V_TOP 5'h1f
`define SMC_VTC_BITS 5'h1f
`define SMC_LUT_DEPTH 32
`endif

// [hdl/smc_pkg.sv]
// types for the slipping motion counters
// assumes smc_defines.svh sits beside it
package smc_pkg;
   typedef logic [3:0] smc_nib_t;
   typedef logic [4:0] smc_dir_t;
   typedef enum logic [1:0] {
      SMC_RST_SET = 2'b01,
      SMC_RST_CLR = 2'b10
   } smc_rst_e;
endpackage

// [hdl/smc_preset_if.sv]
// preset lookup request and answer between top and table
// assumes a single clock domain
`timescale 1ns/1ns
interface smc_preset_if;
   logic [4:0] dir;
   logic go;
   logic [7:0] code;
   modport req (output dir, output go, input code);
   modport rsp (input dir, input go, output code);
endinterface

// [hdl/smc_preset_rom.sv]
// motion code table, registered read data
// assumes request from the same clock domain
`timescale 1ns/1ns
`include "smc_defines.svh"
module smc_preset_rom (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // lookup
   smc_preset_if.rsp lk
);
   import smc_pkg::*;
   // horizontal preset in high nibble, vertical in low nibble (as printed)
   function automatic logic [7:0] lut(input logic [4:0] a);
      logic [7:0] t [0:`SMC_LUT_DEPTH-1];
      t = '{8'h4c, 8'h3c, 8'h3b, 8'h2b, 8'h1b, 8'h1a, 8'h19, 8'h09,
            8'h08, 8'h07, 8'h17, 8'h16, 8'h15, 8'h25, 8'h35, 8'h34,
            8'h44, 8'h54, 8'h55, 8'h65, 8'h75, 8'h76, 8'h77, 8'h87,
            8'h88, 8'h89, 8'h79, 8'h7a, 8'h7b, 8'h6b, 8'h5b, 8'h5c};
      return t[a];
   endfunction
   ////////////////////////////////////////////////////////////////
   // registered read, stop code when go is low
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lk.code <= {`SMC_H_PRESET_STOP, `SMC_V_PRESET_STOP};
      end else if (lk.go) begin
         lk.code <= lut(lk.dir);
      end else begin
         lk.code <= {`SMC_H_PRESET_STOP, `SMC_V_PRESET_STOP};
      end
   end
endmodule

// [hdl/smc_motion.sv]
// slipping motion counters for one pair of cars
// assumes sync chain inputs are pins, synchronised here
`timescale 1ns/1ns
`include "smc_defines.svh"
//
// Overview of operation
// - horizontal twelve bits, vertical eight plus flop
// - horizontal counter steps every pixel clock
// - vertical steps twice per line, not vsync
// - both counters free run beside sync chains
// - vertical short cycle up, long down
// - horizontal short cycle left, long right
// - one unit move per frame with go
// - car window sixteen clocks by eight vertical steps
// - vertical terminal count feeds steering
// - final vertical stage clocks frame counter
// - thirty two entry preset table by direction
// - car reset clears all counter stages
// - start low forces reset flop set
// - start high clears on bit8 rising edge
// - car two reset gated by horizontal decode
// - reset pulses once per play sequence
// - vertical preset inverted, horizontal gated reset
module smc_motion (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // motion code lookup inputs
   input wire logic motion_go_in,
   input wire logic rotation_lsb_in,
   input wire logic [4:1] skid_direction_bit_in,
   // sync chain timing
   input wire logic vclock_in,
   input wire logic vsync_in,
   input wire logic vertical_count_bit8_in,
   input wire logic hchain_decode_in,
   input wire logic vreset_in,
   input wire logic start_in,
   // outputs
   output logic car_window_out,
   output logic vertical_terminal_count_out,
   output logic vertical_final_stage_out,
   output logic car_one_reset_active_high_out,
   output logic car_two_reset_active_high_out,
   output smc_pkg::smc_nib_t h_preset_out,
   output smc_pkg::smc_nib_t v_preset_out
);
   import smc_pkg::*;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops each
   // the sync chains come from another timing source,
   // so every level is treated as asynchronous to clk_in
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic vclk_s, vsync_s, bit8_s, hdec_s, vres_s, start_s;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end else begin
         sync1_r <= {vclock_in, vsync_in, vertical_count_bit8_in,
                     hchain_decode_in, vreset_in, start_in};
         sync2_r <= sync1_r;
      end
   end
   assign {vclk_s, vsync_s, bit8_s, hdec_s, vres_s, start_s} = sync2_r;

   ////////////////////////////////////////////////////////////////
   // delayed vertical clock level for edge detect
   // reset value matches the synchroniser reset, so no false edge
   logic vclk_d_r, bit8_d_r;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vclk_d_r <= 1'b0;
      end else begin
         vclk_d_r <= vclk_s;
      end
   end

   // delayed bit8 level for edge detect
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit8_d_r <= 1'b0;
      end else begin
         bit8_d_r <= bit8_s;
      end
   end

   // vertical step on each clock rise, none during vsync
   logic vstep;
   logic bit8_rise;
   assign vstep = vclk_s & ~vclk_d_r & ~vsync_s;
   assign bit8_rise = bit8_s & ~bit8_d_r;

   ////////////////////////////////////////////////////////////////
   // car reset flop: start low sets, bit8 rise clears
   // start low overrides the clock, like a preset pin
   // the last assignment below keeps start low dominant
   smc_rst_e rst_state_r;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_state_r <= SMC_RST_CLR;
      end else begin
         case (rst_state_r)
            SMC_RST_SET: begin
               if (start_s && bit8_rise) begin
                  rst_state_r <= SMC_RST_CLR;
               end
            end
            SMC_RST_CLR: begin
               if (!start_s) begin
                  rst_state_r <= SMC_RST_SET;
               end
            end
            default: rst_state_r <= SMC_RST_CLR;
         endcase
         if (!start_s) begin
            rst_state_r <= SMC_RST_SET;
         end
      end
   end
   logic car_rst;
   assign car_rst = (rst_state_r == SMC_RST_SET);

   ////////////////////////////////////////////////////////////////
   // car one reset output, registered
   // high for the whole reset pulse
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         car_one_reset_active_high_out <= 1'b0;
      end else begin
         car_one_reset_active_high_out <= car_rst;
      end
   end

   // car two reset output, gated by horizontal decode
   // pulses only in the decoded part of each line
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         car_two_reset_active_high_out <= 1'b0;
      end else begin
         car_two_reset_active_high_out <= car_rst & hdec_s;
      end
   end

   ////////////////////////////////////////////////////////////////
   // motion code lookup
   smc_preset_if lk ();
   assign lk.dir = {skid_direction_bit_in, rotation_lsb_in};
   assign lk.go = motion_go_in;
   smc_preset_rom u_rom (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .lk(lk)
   );

   // table prints the applied preset; recover code bits, then apply
   // vertical path inverts the code bits, so the net value is as printed
   // go low gives the stop code, so the car stands still
   logic [7:0] mcode;
   smc_nib_t h_pre, v_pre;
   assign mcode = {lk.code[7:4], ~lk.code[3:0]};
   assign v_pre = ~mcode[3:0];
   assign h_pre = mcode[7:4] & {4{vres_s}};

   ////////////////////////////////////////////////////////////////
   // horizontal counter: three nibble stages
   // window bits are stages two and one; stage zero picks the pixel
   // one lap is 4096 less the preset; a short lap moves left
   smc_nib_t h_r [3];
   logic [2:0] h_tc;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_h
         if (g == 0) begin : g_c
            assign h_tc[g] = (h_r[g] == `SMC_NIB_MAX);
         end else begin : g_c
            assign h_tc[g] = h_tc[g-1] & (h_r[g] == `SMC_NIB_MAX);
         end
      end
   endgenerate
   logic h_full;
   assign h_full = h_tc[2];
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         h_r <= '{`SMC_NIB_ZERO, `SMC_NIB_ZERO, `SMC_NIB_ZERO};
      end else if (car_rst) begin
         h_r <= '{`SMC_NIB_ZERO, `SMC_NIB_ZERO, `SMC_NIB_ZERO};
      end else if (h_full) begin
         h_r[0] <= h_pre;
         h_r[1] <= `SMC_H_RELOAD_NIB1;
         h_r[2] <= `SMC_H_RELOAD_NIB2;
      end else begin
         h_r[0] <= h_r[0] + 4'h1;
         if (h_tc[0]) begin
            h_r[1] <= h_r[1] + 4'h1;
         end
         if (h_tc[1]) begin
            h_r[2] <= h_r[2] + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // vertical counter: two nibble stages plus final flop
   // steps only on vstep, so the preset slips the frame phase
   // one lap is 256 less the preset; a larger preset is shorter
   smc_nib_t v0_r, v1_r;
   logic vfin_r;
   logic v0_tc, v_full;
   assign v0_tc = (v0_r == `SMC_NIB_MAX);
   assign v_full = v0_tc & (v1_r == `SMC_NIB_MAX);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         v0_r <= `SMC_NIB_ZERO;
         v1_r <= `SMC_NIB_ZERO;
      end else if (car_rst) begin
         v0_r <= `SMC_NIB_ZERO;
         v1_r <= `SMC_NIB_ZERO;
      end else if (vstep) begin
         if (v_full) begin
            v0_r <= v_pre;
            v1_r <= `SMC_V_RELOAD_HI;
         end else begin
            v0_r <= v0_r + 4'h1;
            if (v0_tc) begin
               v1_r <= v1_r + 4'h1;
            end
         end
      end
   end

   // final vertical stage, toggles at each wrap
   // drives the car frame counter
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vfin_r <= 1'b0;
      end else if (car_rst) begin
         vfin_r <= 1'b0;
      end else if (vstep && v_full) begin
         vfin_r <= ~vfin_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // decodes of the counter stages
   logic win_h, win_v, vtc;
   assign win_h = (h_r[2] == `SMC_WIN_H_NIB2) && (h_r[1] == `SMC_WIN_H_NIB1);
   assign win_v = ({v1_r, v0_r[3]} == `SMC_WIN_V_TOP);
   assign vtc = ({v1_r, v0_r[3]} == `SMC_VTC_BITS) & vfin_r;

   // car window output
   // sixteen pixels by eight vertical steps
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         car_window_out <= 1'b0;
      end else begin
         car_window_out <= win_h & win_v;
      end
   end

   // vertical terminal count output
   // feeds the steering rate input
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vertical_terminal_count_out <= 1'b0;
      end else begin
         vertical_terminal_count_out <= vtc;
      end
   end

   // final vertical stage output
   // one period per two vertical laps
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         vertical_final_stage_out <= 1'b0;
      end else begin
         vertical_final_stage_out <= vfin_r;
      end
   end

   // horizontal preset in use
   // zero while vertical reset is low
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         h_preset_out <= `SMC_NIB_ZERO;
      end else begin
         h_preset_out <= h_pre;
      end
   end

   // vertical preset in use
   // stop code gives the neutral lap
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         v_preset_out <= `SMC_NIB_ZERO;
      end else begin
         v_preset_out <= v_pre;
      end
   end
endmodule

// [tb/smc_sync_model.sv]
// model of the sync chains seen by the motion counters
// assumes the bench steers vsync and vertical reset
`timescale 1ns/1ns
module smc_sync_model (
   // clock and controls
   input wire logic clk_in, freeze_in, vrst_off_in,
   // chain outputs
   output logic vclock_out, vsync_out, bit8_out, hdec_out, vreset_out
);
   logic [12:0] cnt_r = 13'h0000;
   // free running chain, moves on the falling edge
   always @(negedge clk_in) begin
      cnt_r <= cnt_r + 13'h0001;
   end
   // two vertical pulses per line, eight clocks apart
   assign vclock_out = cnt_r[2];
   assign vsync_out = freeze_in;
   assign bit8_out = cnt_r[12];
   assign hdec_out = cnt_r[3];
   assign vreset_out = ~vrst_off_in;
endmodule

// [tb/smc_motion_asserts.sv]
// checks on the motion counter ports
// assumes a bind into smc_motion, one clock
`timescale 1ns/1ns
module smc_motion_asserts (
   // clock and reset
   input wire logic clk_in, rstn_in,
   // inputs
   input wire logic motion_go_in, vsync_in, start_in, vertical_count_bit8_in, vreset_in,
   // outputs
   input wire logic car_window_out, vertical_terminal_count_out, vertical_final_stage_out,
   input wire logic car_one_reset_active_high_out,
   input wire smc_pkg::smc_nib_t h_preset_out, v_preset_out
);
   import smc_pkg::*;
   wire logic r1 = car_one_reset_active_high_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   //////////////////////////////////////////
   // window held sixteen clocks
   sequence s_win16; car_window_out[*8] ##1 car_window_out[*8]; endsequence
   property p_stop; (!motion_go_in && vreset_in)[*6]
      |-> h_preset_out == 4'h4 && v_preset_out == 4'h8; endproperty
   a_stop: assert property (p_stop) else $error("stop preset");
   property p_gate; !vreset_in[*6] |-> h_preset_out == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("gated preset");
   property p_set; !start_in[*3] |-> ##[1:4] r1; endproperty
   a_set: assert property (p_set) else $error("no car reset");
   property p_clr; start_in[*8] ##0 $rose(vertical_count_bit8_in) |-> ##[1:6] !r1; endproperty
   a_clr: assert property (p_clr) else $error("car reset kept");
   property p_once; $rose(r1) |-> !($past(start_in, 4) && $past(start_in, 5)); endproperty
   a_once: assert property (p_once) else $error("stray car reset");
   property p_held; r1[*3] |-> !car_window_out && !vertical_terminal_count_out
      && !vertical_final_stage_out; endproperty
   a_held: assert property (p_held) else $error("counter ran in reset");
   property p_win; s_win16 |=> !car_window_out; endproperty
   a_win: assert property (p_win) else $error("window too wide");
   property p_frz; vsync_in[*8] |=> $stable(vertical_final_stage_out)
      && $stable(vertical_terminal_count_out); endproperty
   a_frz: assert property (p_frz) else $error("vertical moved in vsync");
endmodule
// attach to the motion counter block
bind smc_motion smc_motion_asserts u_chk (.clk_in, .rstn_in, .motion_go_in, .vsync_in,
   .start_in, .vertical_count_bit8_in, .vreset_in, .car_window_out,
   .vertical_terminal_count_out, .vertical_final_stage_out,
   .car_one_reset_active_high_out, .h_preset_out, .v_preset_out);

// [tb/smc_motion_tb.sv]
// self-checking bench for the motion counters
// assumes the sync model and checker compile first
`timescale 1ns/1ns
module smc_motion_tb;
   import smc_pkg::*;
   // expected {h, v} presets per direction code, code 31 first
   localparam logic [255:0] TBL = {128'h5c5b6b7b_7a798988_87777675_65555444,
      128'h34352515_16170708_09191a1b_2b3b3c4c};
   logic clk_in = 1'b0, rstn_in = 1'b0, go = 1'b1, start = 1'b1, frz = 1'b0, vro = 1'b0;
   logic [4:0] code = 5'h00;
   logic vck, vs, b8, hd, vr, win, vtc, fin, r1, r2;
   smc_nib_t hp, vp;
   int bad_count = 0, checks = 0, cyc, pul;
   //////////////////////////////////////////
   // clock and instances
   always #5 clk_in = ~clk_in;
   smc_sync_model far (.clk_in, .freeze_in(frz), .vrst_off_in(vro), .vclock_out(vck),
      .vsync_out(vs), .bit8_out(b8), .hdec_out(hd), .vreset_out(vr));
   smc_motion dut (.clk_in, .rstn_in, .motion_go_in(go), .rotation_lsb_in(code[0]),
      .skid_direction_bit_in(code[4:1]), .vclock_in(vck), .vsync_in(vs),
      .vertical_count_bit8_in(b8), .hchain_decode_in(hd), .vreset_in(vr), .start_in(start),
      .car_window_out(win), .vertical_terminal_count_out(vtc), .vertical_final_stage_out(fin),
      .car_one_reset_active_high_out(r1), .car_two_reset_active_high_out(r2),
      .h_preset_out(hp), .v_preset_out(vp));
   // compare and count
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // clocks and vertical pulses between two window rises or final stage flips
   task automatic span(input bit w);
      logic p, q, v;
      int e;
      cyc = 0;
      pul = 0;
      e = 0;
      v = vck;
      p = w ? win : fin;
      for (int k = 0; k < 20000 && e < 2; k++) begin
         tick(1);
         q = w ? win : fin;
         if (e == 1) begin
            cyc++;
            pul += int'(!v && vck);
         end
         if (w ? (!p && q) : (p !== q)) e++;
         p = q;
         v = vck;
      end
      if (e < 2) bad_count++;
   endtask
   // every direction code, then stop, then gated horizontal
   task automatic t_table;
      for (int i = 0; i < 32; i++) begin
         code = 5'(i);
         tick(6);
         cmp({8'h00, hp, vp}, {8'h00, TBL[8*i +: 8]});
      end
      go = 1'b0;
      tick(6);
      cmp({8'h00, hp, vp}, 16'h0048);
      vro = 1'b1;
      tick(6);
      cmp({12'h000, hp}, 16'h0000);
      vro = 1'b0;
      go = 1'b1;
   endtask
   // vertical lap length follows the preset
   task automatic t_vert(input logic [4:0] c);
      code = c;
      tick(8);
      span(1'b0);
      cmp(16'(pul), {8'h00, 8'h00 - {4'h0, TBL[8*c +: 4]}});
   endtask
   // horizontal lap length with vertical frozen in the window
   task automatic t_horiz(input logic [4:0] c);
      code = c;
      for (int k = 0; k < 9000 && vtc !== 1'b1; k++) tick(1);
      frz = 1'b1;
      span(1'b1);
      cmp(16'(cyc), 16'h1000 - {12'h000, TBL[8*c+4 +: 4]});
      frz = 1'b0;
   endtask
   // start pulse sets car reset, bit8 rise clears it
   task automatic t_start;
      while (b8 !== 1'b0) tick(1);
      while (b8 !== 1'b1) tick(1);
      start = 1'b0;
      tick(4);
      start = 1'b1;
      tick(4);
      cmp({12'h000, r1, win, vtc, fin}, 16'h0008);
      pul = 0;
      for (int k = 0; k < 9000 && r1 !== 1'b0; k++) begin
         tick(1);
         pul += int'(r2 === 1'b1);
      end
      cmp({15'h0000, r1}, 16'h0000);
      cmp({15'h0000, pul != 0}, 16'h0001);
      tick(4);
      cmp({15'h0000, r2}, 16'h0000);
   endtask
   // verdict
   task automatic stop_test;
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // scenario order
   initial begin
      tick(2);
      rstn_in = 1'b1;
      t_table();
      t_vert(5'h00);
      t_vert(5'h09);
      t_horiz(5'h00);
      t_horiz(5'h17);
      t_start();
      stop_test();
   end
   // watchdog
   initial begin
      #800000;
      bad_count++;
      stop_test();
   end
endmodule
